// ===== verilog/tss_consts.svh
/*
  Constants of the time slot switch: register fields, reset values,
  memory geometry, slot schedule and timing figures.
  Assumes it is included by bare name from the design files.
*/
`ifndef TSS_CONSTS_SVH
`define TSS_CONSTS_SVH

// ============================================================
// Register map
`define TSS_CTRL_OFFSET        6'h00
`define TSS_ADDR_TOP_BIT       5
`define TSS_CTRL_RESET         8'h00
`define TSS_CTRL_MASK          8'hdb
`define TSS_CTRL_SPLIT_BIT     7
`define TSS_CTRL_PE_BIT        6
`define TSS_CTRL_MSEL_HI       4
`define TSS_CTRL_MSEL_LO       3
`define TSS_CTRL_STREAM_HI     1
`define TSS_CTRL_STREAM_LO     0

// ============================================================
// Connection memory fields
`define TSS_HI_SRC_BIT         2
`define TSS_HI_OE_BIT          0
`define TSS_LOW_STREAM_HI      6
`define TSS_LOW_STREAM_LO      5
`define TSS_LOW_CHAN_HI        4
`define TSS_LOW_CHAN_LO        0

// ============================================================
// Frame geometry
`define TSS_STREAMS            4
`define TSS_CHANNELS           32
`define TSS_LAST_POS           4'hf

// ============================================================
// Slot schedule, step number inside one channel time
`define TSS_FETCH_STEP0        3'h0
`define TSS_WRITE_STEP0        3'h1
`define TSS_FETCH_STEP1        3'h2
`define TSS_FETCH_STEP2        3'h3
`define TSS_WRITE_STEP1        3'h4
`define TSS_FETCH_STEP3        3'h5
`define TSS_WRITE_STEP2        3'h6
`define TSS_WRITE_STEP3        3'h7

// ============================================================
// Timing
`define TSS_SYS_CLK_MHZ        20
`define TSS_SCLK_PERIOD_NS     244
`define TSS_STOP_PERIODS       2
`define TSS_ACK_SLOW_MAX_HALF  9

`endif

// ===== verilog/tss_pkg.sv
/*
  Types shared by the time slot switch design.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package tss_pkg;

  // ============================================================
  // Memory select field
  typedef enum logic [1:0] {
    MSEL_NONE = 2'b00,
    MSEL_DATA = 2'b01,
    MSEL_LOW  = 2'b10,
    MSEL_HIGH = 2'b11
  } tss_msel_type;

  // ============================================================
  // Processor port states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_WAIT = 2'b01,
    BUS_ACK  = 2'b10
  } tss_bus_state_type;

endpackage

// ===== verilog/tss_serial_out.sv
/*
  Parallel to serial converter for one output stream.
  Assumes load and shift pulses from the frame timing of the parent.
*/
module tss_serial_out (
  input  logic       sys_clk,
  input  logic       rst_b,
  input  logic       clk_en,
  input  logic       load,
  input  logic       shift,
  input  logic [7:0] load_data,
  input  logic       load_en,
  input  logic       drive_ok,
  output logic       ser_out,
  output logic       ser_oe
);

  logic [7:0] shreg;
  logic       chan_en;

  // ============================================================
  // Shift register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      shreg   <= 8'h00;
      chan_en <= 1'b0;
    end else if (clk_en) begin
      if (load) begin
        shreg   <= load_data;
        chan_en <= load_en;
      end else if (shift) begin
        shreg <= {shreg[6:0], 1'b0};
      end
    end
  end

  // ============================================================
  // Pin drive
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ser_out <= 1'b0;
      ser_oe  <= 1'b0;
    end else if (clk_en) begin
      ser_out <= shreg[7];
      ser_oe  <= drive_ok & chan_en;
    end
  end

endmodule // tss_serial_out

// ===== verilog/tss_switch.sv
/*
  Time slot switch, 4 streams of 32 channels: processor port, control
  register, data and connection memories, per channel output control.
  Assumes all pins are asynchronous to sys_clk and that sys_clk is well
  above twice the serial clock rate.
*/
//
// Contract
// - Global processor bit sends low connection byte on every channel.
// - Global processor bit forces channel-source and output-enable to one.
// - Otherwise source bit picks processor byte or switched input channel.
// - Drive pin low floats all serial outputs; else per channel enable rules.
// - Two-channel delay only from stream 0 to 1-3, 1 to 3.
// - Reset floats outputs, clears registers and frame counter, loads watchdog as stopped; memories not.
// - Top address low selects control; high selects channel 0 to 31.
// - Control writes acknowledge fast; other accesses wait a memory slot.
// - Memory select: 00 none, 01 data read-only, 10 low, 11 high.
// - Control bits 1-0 choose the stream exposed in the window.
// - High connection memory keeps bits 2 and 0; others read zero.
// - Low byte holds source stream in 6-5 and channel in 4-0.
// - Processor sourced channels send all eight low bits unchanged.
// - Stopped serial clock floats outputs but keeps memories.
// - Split bit: reads from data memory, writes to selected memory.
// - Each stream carries 32 eight-bit channels per frame.
// - Output channel data is fetched during the preceding channel.
// - Acknowledge output, open drain, low marks transfer completion.
`include "tss_consts.svh"

module tss_switch
  import tss_pkg::*;
#(
  parameter int unsigned STOP_LIMIT = ((`TSS_STOP_PERIODS *
      `TSS_SCLK_PERIOD_NS * `TSS_SYS_CLK_MHZ) + 999) / 1000
) (
  input  logic       sys_clk,
  input  logic       rst_b,
  input  logic       clk_en,
  input  logic       serial_shift_clock_b,
  input  logic       frame_sync_pulse_b,
  input  logic [3:0] serial_inputs,
  input  logic       master_output_drive,
  input  logic       chip_select_b,
  input  logic       bus_data_strobe,
  input  logic       bus_read_write,
  input  logic [5:0] bus_address,
  input  logic [7:0] bus_data_in,
  output logic [7:0] bus_data_out,
  output logic       bus_data_oe,
  output logic       transfer_acknowledge_b_out,
  output logic       transfer_acknowledge_b_oe,
  output logic [3:0] serial_outputs,
  output logic [3:0] serial_outputs_oe
);

  localparam logic [2:0] FETCH_STEP [4] = '{`TSS_FETCH_STEP0,
      `TSS_FETCH_STEP1, `TSS_FETCH_STEP2, `TSS_FETCH_STEP3};
  localparam logic [2:0] WRITE_STEP [4] = '{`TSS_WRITE_STEP0,
      `TSS_WRITE_STEP1, `TSS_WRITE_STEP2, `TSS_WRITE_STEP3};
  localparam logic [7:0] STOP_CNT = 8'(STOP_LIMIT);

  // ============================================================
  // Input synchronisers
  logic [23:0] async_in;
  logic [23:0] sync_1;
  logic [23:0] sync_2;
  logic        sclk_s;
  logic        frame_b_s;
  logic [3:0]  rx_s;
  logic        ode_s;
  logic        cs_b_s;
  logic        ds_s;
  logic        rw_s;
  logic [5:0]  addr_s;
  logic [7:0]  din_s;

  assign async_in = {serial_shift_clock_b, frame_sync_pulse_b,
                     serial_inputs, master_output_drive, chip_select_b,
                     bus_data_strobe, bus_read_write, bus_address,
                     bus_data_in};

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Idle pin levels, so no false clock edge follows reset
      sync_1 <= 24'hc10000;
      sync_2 <= 24'hc10000;
    end else if (clk_en) begin
      sync_1 <= async_in;
      sync_2 <= sync_1;
    end
  end

  assign {sclk_s, frame_b_s, rx_s, ode_s, cs_b_s, ds_s, rw_s, addr_s,
          din_s} = sync_2;

  // ============================================================
  // Frame timing
  logic       sclk_prev;
  logic       tick;
  logic [8:0] bit_cnt;
  logic [3:0] pos;
  logic [4:0] chan;
  logic [4:0] next_chan;
  logic [2:0] step;
  logic       ev;
  logic       last_pos;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_prev <= 1'b1;
    end else if (clk_en) begin
      sclk_prev <= sclk_s;
    end
  end

  assign tick      = sclk_prev & ~sclk_s;
  assign pos       = bit_cnt[3:0];
  assign chan      = bit_cnt[8:4];
  assign next_chan = chan + 5'h01;
  assign step      = pos[3:1];
  assign ev        = tick & ~pos[0];
  assign last_pos  = tick & (pos == `TSS_LAST_POS);

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt <= 9'h000;
    end else if (clk_en && tick) begin
      if (!frame_b_s) begin
        bit_cnt <= 9'h000;
      end else begin
        bit_cnt <= bit_cnt + 9'h001;
      end
    end
  end

  // ============================================================
  // Serial clock watchdog
  logic [7:0] idle_cnt;
  logic       sclk_stopped;

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      idle_cnt <= STOP_CNT;
    end else if (clk_en) begin
      if (tick) begin
        idle_cnt <= 8'h00;
      end else if (idle_cnt != STOP_CNT) begin
        idle_cnt <= idle_cnt + 8'h01;
      end
    end
  end

  assign sclk_stopped = (idle_cnt == STOP_CNT);

  // ============================================================
  // Serial to parallel
  logic [7:0] rx_shift [4];
  logic [7:0] rx_hold  [4];
  logic [4:0] hold_chan;

  for (genvar s = 0; s < `TSS_STREAMS; s++) begin : g_rx
    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        rx_shift[s] <= 8'h00;
        rx_hold[s]  <= 8'h00;
      end else if (clk_en && tick && pos[0]) begin
        rx_shift[s] <= {rx_shift[s][6:0], rx_s[s]};
        if (pos == `TSS_LAST_POS) begin
          rx_hold[s] <= {rx_shift[s][6:0], rx_s[s]};
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      hold_chan <= 5'h00;
    end else if (clk_en && last_pos) begin
      hold_chan <= chan;
    end
  end

  // ============================================================
  // Control register and memories
  logic [7:0] ctrl;
  logic [7:0] data_mem [128];
  logic [7:0] low_mem  [128];
  logic [1:0] high_mem [128];
  logic       ctrl_pe;
  logic       ctrl_split;
  tss_msel_type ctrl_msel;
  logic [6:0] cpu_addr;

  assign ctrl_pe    = ctrl[`TSS_CTRL_PE_BIT];
  assign ctrl_split = ctrl[`TSS_CTRL_SPLIT_BIT];
  assign ctrl_msel  = tss_msel_type'(ctrl[`TSS_CTRL_MSEL_HI:
                                          `TSS_CTRL_MSEL_LO]);
  assign cpu_addr   = {ctrl[`TSS_CTRL_STREAM_HI:`TSS_CTRL_STREAM_LO],
                       addr_s[4:0]};

  always_ff @(posedge sys_clk) begin
    if (clk_en && ev) begin
      for (int s = 0; s < `TSS_STREAMS; s++) begin
        if (step == WRITE_STEP[s]) begin
          data_mem[{2'(s), hold_chan}] <= rx_hold[s];
        end
      end
    end
  end

  // ============================================================
  // Output fetch and converters
  logic [7:0] pend_data [4];
  logic [3:0] pend_en;
  logic       drive_ok;

  assign drive_ok = ode_s & ~sclk_stopped;

  for (genvar s = 0; s < `TSS_STREAMS; s++) begin : g_tx
    logic [6:0] cm_addr;
    logic [7:0] low_byte;
    logic [1:0] high_bits;
    logic       from_proc;
    logic       chan_en;
    logic [7:0] out_byte;

    assign cm_addr   = {2'(s), next_chan};
    assign low_byte  = low_mem[cm_addr];
    assign high_bits = high_mem[cm_addr];
    assign from_proc = ctrl_pe | high_bits[1];
    assign chan_en   = ctrl_pe | high_bits[0];
    assign out_byte  = from_proc ? low_byte :
        data_mem[{low_byte[`TSS_LOW_STREAM_HI:`TSS_LOW_STREAM_LO],
                  low_byte[`TSS_LOW_CHAN_HI:`TSS_LOW_CHAN_LO]}];

    always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
        pend_data[s] <= 8'h00;
        pend_en[s]   <= 1'b0;
      end else if (clk_en && ev && step == FETCH_STEP[s]) begin
        pend_data[s] <= out_byte;
        pend_en[s]   <= chan_en;
      end
    end

    tss_serial_out u_out (
      .sys_clk   (sys_clk),
      .rst_b     (rst_b),
      .clk_en    (clk_en),
      .load      (last_pos),
      .shift     (tick & pos[0] & ~last_pos),
      .load_data (pend_data[s]),
      .load_en   (pend_en[s]),
      .drive_ok  (drive_ok),
      .ser_out   (serial_outputs[s]),
      .ser_oe    (serial_outputs_oe[s])
    );
  end

  // ============================================================
  // Processor port
  tss_bus_state_type state;
  logic       sel;
  logic       is_ctrl;
  logic       cpu_go;
  logic [7:0] rd_val;

  assign sel     = ~cs_b_s & ds_s;
  assign is_ctrl = ~addr_s[`TSS_ADDR_TOP_BIT];
  assign cpu_go  = (state == BUS_WAIT) & sel & tick & pos[0];

  always_comb begin
    rd_val = 8'h00;
    if (is_ctrl) begin
      rd_val = ctrl & `TSS_CTRL_MASK;
    end else if (ctrl_split || ctrl_msel == MSEL_DATA) begin
      rd_val = data_mem[cpu_addr];
    end else if (ctrl_msel == MSEL_LOW) begin
      rd_val = low_mem[cpu_addr];
    end else if (ctrl_msel == MSEL_HIGH) begin
      rd_val = {5'h00, high_mem[cpu_addr][1], 1'b0,
                high_mem[cpu_addr][0]};
    end
  end

  always_ff @(posedge sys_clk) begin
    if (clk_en && cpu_go && !rw_s && !is_ctrl) begin
      if (ctrl_msel == MSEL_LOW) begin
        low_mem[cpu_addr] <= din_s;
      end else if (ctrl_msel == MSEL_HIGH) begin
        high_mem[cpu_addr] <= {din_s[`TSS_HI_SRC_BIT],
                               din_s[`TSS_HI_OE_BIT]};
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state                     <= BUS_IDLE;
      ctrl                      <= `TSS_CTRL_RESET;
      bus_data_out              <= 8'h00;
      bus_data_oe               <= 1'b0;
      transfer_acknowledge_b_oe <= 1'b0;
    end else if (clk_en) begin
      case (state)
        BUS_IDLE: begin
          if (sel) begin
            if (is_ctrl && !rw_s) begin
              ctrl                      <= din_s & `TSS_CTRL_MASK;
              transfer_acknowledge_b_oe <= 1'b1;
              state                     <= BUS_ACK;
            end else begin
              state <= BUS_WAIT;
            end
          end
        end
        BUS_WAIT: begin
          if (!sel) begin
            state <= BUS_IDLE;
          end else if (cpu_go) begin
            bus_data_out              <= rd_val;
            bus_data_oe               <= rw_s;
            transfer_acknowledge_b_oe <= 1'b1;
            state                     <= BUS_ACK;
          end
        end
        BUS_ACK: begin
          if (!sel) begin
            bus_data_oe               <= 1'b0;
            transfer_acknowledge_b_oe <= 1'b0;
            state                     <= BUS_IDLE;
          end
        end
        default: begin
          state <= BUS_IDLE;
        end
      endcase
    end
  end

  // Open drain level, only ever pulled low
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      transfer_acknowledge_b_out <= 1'b0;
    end else if (clk_en) begin
      transfer_acknowledge_b_out <= 1'b0;
    end
  end

endmodule // tss_switch

// ===== verif/tss_switch_monitor.sv
/* Port checker of the time slot switch: bus handshake, output drive.
   Assumes it is bound into tss_switch with clk_en held high. */
module tss_switch_monitor #(
  parameter int unsigned STOP_LIMIT = 10
) (
  input logic       sys_clk,
  input logic       rst_b,
  input logic       serial_shift_clock_b,
  input logic       master_output_drive,
  input logic       chip_select_b,
  input logic       bus_data_strobe,
  input logic       bus_read_write,
  input logic [5:0] bus_address,
  input logic       bus_data_oe,
  input logic       transfer_acknowledge_b_oe,
  input logic [3:0] serial_outputs_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic       sel;
  logic       sclk_last;
  logic [5:0] still_cnt;

  assign sel = !chip_select_b && bus_data_strobe;

  // ==========
  // Cycles since the serial clock pin last moved
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_last <= 1'b1;
      still_cnt <= 6'h00;
    end else begin
      sclk_last <= serial_shift_clock_b;
      if (serial_shift_clock_b != sclk_last) begin
        still_cnt <= 6'h00;
      end else if (still_cnt != 6'h3f) begin
        still_cnt <= still_cnt + 6'h01;
      end
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // ==========
  // Assertions
  drive_low_float_a: assert property (
    !master_output_drive [*5] |-> serial_outputs_oe == 4'h0)
    else $error("serial output driven with drive pin low");
  reset_float_a: assert property (
    $rose(rst_b) |-> serial_outputs_oe == 4'h0
      && !transfer_acknowledge_b_oe && !bus_data_oe)
    else $error("output enabled straight after reset");
  clock_stop_float_a: assert property (
    still_cnt > STOP_LIMIT + 4 |-> serial_outputs_oe == 4'h0)
    else $error("serial output driven with clock stopped");
  fast_ctrl_ack_a: assert property (
    $rose(sel) && !bus_read_write && !bus_address[5]
      |-> ##[2:4] $rose(transfer_acknowledge_b_oe))
    else $error("control write not acknowledged fast");
  slow_ack_bound_a: assert property (
    $rose(sel) |-> ##[2:30] transfer_acknowledge_b_oe)
    else $error("access not acknowledged in time");
  ack_cause_a: assert property (
    $rose(transfer_acknowledge_b_oe) |-> $past(sel, 2))
    else $error("acknowledge without a request");
  ack_hold_a: assert property (
    transfer_acknowledge_b_oe && sel |=> transfer_acknowledge_b_oe)
    else $error("acknowledge dropped while strobe held");
  ack_release_a: assert property (
    $fell(sel) |-> ##[1:4] !transfer_acknowledge_b_oe)
    else $error("acknowledge not released");
  read_drive_a: assert property (
    $rose(transfer_acknowledge_b_oe)
      |-> bus_data_oe == $past(bus_read_write, 2))
    else $error("data bus drive does not match direction");

  cover property ($rose(transfer_acknowledge_b_oe) && bus_data_oe);
  cover property (still_cnt > STOP_LIMIT + 4);
  cover property (serial_outputs_oe == 4'hf);
endmodule  // tss_switch_monitor

bind tss_switch tss_switch_monitor #(.STOP_LIMIT(STOP_LIMIT)) mon_u (
  .sys_clk, .rst_b, .serial_shift_clock_b, .master_output_drive,
  .chip_select_b, .bus_data_strobe, .bus_read_write, .bus_address,
  .bus_data_oe, .transfer_acknowledge_b_oe, .serial_outputs_oe
);

// ===== verif/tss_highway_model.sv
/* Serial highway model: clock, frame pulse, input streams, and a
   recorder of output bytes and enables per stream and channel.
   Assumes a 4.096 MHz clock that stops high when run is low. */
module tss_highway_model (
  input  logic       run,
  output logic       serial_shift_clock_b,
  output logic       frame_sync_pulse_b,
  output logic [3:0] serial_inputs,
  input  logic [3:0] serial_outputs,
  input  logic [3:0] serial_outputs_oe
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [8:0] cnt = 9'h000;
  int         frm = 0;
  logic [8:0] nxt;
  logic [7:0] b;
  logic [7:0] out_byte [4][32];
  logic       out_oe   [4][32];
  int         out_frm  [4][32];

  function automatic logic [7:0] in_byte(int s, int c, int f);
    return {f[0], s[1:0], c[4:0]};
  endfunction

  initial begin
    serial_shift_clock_b = 1'b1;
    frame_sync_pulse_b = 1'b1;
    serial_inputs = 4'h0;
    #7;
    forever begin
      #122;
      if (run || !serial_shift_clock_b) begin
        serial_shift_clock_b = ~serial_shift_clock_b;
      end
    end
  end

  always @(negedge serial_shift_clock_b) begin
    if (cnt == 9'h1ff) begin
      frm++;
    end
    cnt++;
  end

  always @(posedge serial_shift_clock_b) begin
    nxt = cnt + 9'h001;
    frame_sync_pulse_b <= (nxt != 9'h000);
    for (int s = 0; s < 4; s++) begin
      b = in_byte(s, cnt[8:4], frm);
      serial_inputs[s] <= b[7 - cnt[3:1]];
      if (cnt[0]) begin
        out_byte[s][cnt[8:4]][7 - cnt[3:1]] = serial_outputs[s];
      end
      if (cnt[3:0] == 4'h8) begin
        out_oe[s][cnt[8:4]] = serial_outputs_oe[s];
        out_frm[s][cnt[8:4]] = frm;
      end
    end
  end
endmodule  // tss_highway_model

// ===== verif/tss_switch_tb_top.sv
/* Testbench of the time slot switch: registers, switching, drive pin,
   clock stop and reset. Assumes the highway model and bound checker. */
module tss_switch_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic       sys_clk = 1'b0;
  logic       rst_b, run, master_output_drive;
  logic       chip_select_b, bus_data_strobe, bus_read_write;
  logic       serial_shift_clock_b, frame_sync_pulse_b;
  logic       bus_data_oe, transfer_acknowledge_b_oe;
  logic [3:0] serial_inputs, serial_outputs, serial_outputs_oe;
  logic [5:0] bus_address;
  logic [7:0] bus_data_in, bus_data_out, q;
  int         n_mismatch = 0;
  int         cmp_count = 0;
  int         n_wait;

  always #25 sys_clk = ~sys_clk;

  tss_switch #(.STOP_LIMIT(6)) dut_u (
    .sys_clk, .rst_b, .clk_en(1'b1), .serial_shift_clock_b,
    .frame_sync_pulse_b, .serial_inputs, .master_output_drive,
    .chip_select_b, .bus_data_strobe, .bus_read_write, .bus_address,
    .bus_data_in, .bus_data_out, .bus_data_oe,
    .transfer_acknowledge_b_out(), .transfer_acknowledge_b_oe,
    .serial_outputs, .serial_outputs_oe
  );

  tss_highway_model p_u (
    .run, .serial_shift_clock_b, .frame_sync_pulse_b, .serial_inputs,
    .serial_outputs, .serial_outputs_oe
  );

  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask

  // One bus access, held until acknowledge, then released
  task automatic acc(input logic r, input logic [5:0] a,
                     input logic [7:0] d);
    n_wait = 0;
    chip_select_b = 1'b0;
    bus_data_strobe = 1'b1;
    bus_read_write = r;
    bus_address = a;
    bus_data_in = d;
    do begin
      @(posedge sys_clk);
      n_wait++;
    end while (transfer_acknowledge_b_oe !== 1'b1 && n_wait < 40);
    q = bus_data_out;
    if (n_wait >= 40) begin
      n_mismatch++;
      $display("ERROR %0t ns: no acknowledge", $time);
    end
    #1;
    chip_select_b = 1'b1;
    bus_data_strobe = 1'b0;
    repeat (5) @(posedge sys_clk);
    #1;
  endtask

  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    acc(1'b0, a, d);
  endtask

  task automatic rd(input logic [5:0] a, input logic [7:0] e,
                    input logic [7:0] m = 8'hff);
    acc(1'b1, a, 8'h00);
    chk(q & m, e);
  endtask

  task automatic wait_frames(input int n);
    repeat (n) @(p_u.frm);
    @(posedge sys_clk);
    #1;
  endtask

  initial begin
    #3ms;
    n_mismatch++;
    $display("ERROR %0t ns: watchdog expired", $time);
    finish_test();
  end

  initial begin
    rst_b = 1'b0;
    run = 1'b1;
    master_output_drive = 1'b0;
    chip_select_b = 1'b1;
    bus_data_strobe = 1'b0;
    bus_read_write = 1'b1;
    bus_address = 6'h00;
    bus_data_in = 8'h00;
    repeat (3) @(posedge sys_clk);
    #1;
    rst_b = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    chk({4'h0, serial_outputs_oe}, 8'h00);
    rd(6'h00, 8'h00);
    wr(6'h1f, 8'hff);
    chk({7'h00, n_wait <= 4}, 8'h01);
    rd(6'h05, 8'hdb);
    $display("test registers done");
    for (int s = 0; s < 4; s++) begin
      wr(6'h00, 8'h18 | 8'(s));
      for (int c = 0; c < 32; c++) begin
        wr(6'h20 | 6'(c), 8'h00);
      end
    end
    chk({7'h00, n_wait <= 26}, 8'h01);
    wr(6'h00, 8'h18);
    wr(6'h29, 8'h05);
    wr(6'h25, 8'hfb);
    rd(6'h25, 8'h01);
    wr(6'h00, 8'h19);
    wr(6'h25, 8'h01);
    wr(6'h00, 8'h10);
    wr(6'h29, 8'ha5);
    wr(6'h25, 8'h63);
    wr(6'h00, 8'h11);
    wr(6'h25, 8'h03);
    wr(6'h00, 8'h00);
    rd(6'h29, 8'h00);
    wr(6'h29, 8'h11);
    wr(6'h00, 8'h10);
    rd(6'h29, 8'ha5);
    wait_frames(1);
    wr(6'h00, 8'h90);
    wr(6'h2a, 8'h77);
    rd(6'h2a, 8'h0a, 8'h7f);
    wr(6'h00, 8'h10);
    rd(6'h2a, 8'h77);
    wr(6'h00, 8'h0b);
    rd(6'h23, 8'h63, 8'h7f);
    $display("test memories done");
    master_output_drive = 1'b1;
    wait_frames(2);
    chk({7'h00, p_u.out_oe[0][0]}, 8'h00);
    chk({7'h00, p_u.out_oe[0][9]}, 8'h01);
    chk(p_u.out_byte[0][9], 8'ha5);
    chk(p_u.out_byte[1][5], p_u.in_byte(0, 3, p_u.out_frm[1][5]));
    chk(p_u.out_byte[0][5],
        p_u.in_byte(3, 3, p_u.out_frm[0][5] - 1));
    wr(6'h00, 8'h40);
    wait_frames(2);
    chk({7'h00, p_u.out_oe[2][0]}, 8'h01);
    chk(p_u.out_byte[1][5], 8'h03);
    chk(p_u.out_byte[0][5], 8'h63);
    $display("test switching done");
    master_output_drive = 1'b0;
    wait_frames(1);
    chk({7'h00, p_u.out_oe[0][9]}, 8'h00);
    master_output_drive = 1'b1;
    run = 1'b0;
    repeat (40) @(posedge sys_clk);
    #1;
    chk({4'h0, serial_outputs_oe}, 8'h00);
    run = 1'b1;
    wait_frames(1);
    wr(6'h00, 8'h51);
    rd(6'h25, 8'h03);
    $display("test drive and clock stop done");
    rst_b = 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
    chk({4'h0, serial_outputs_oe}, 8'h00);
    rst_b = 1'b1;
    repeat (2) @(posedge sys_clk);
    #1;
    rd(6'h00, 8'h00);
    $display("test reset done");
    finish_test();
  end
endmodule  // tss_switch_tb_top
